// ---- src/expa_pkg.sv ----
// Package for the exception priority arbiter: types, encodings, reset values
package expa_pkg;

   // Encoded cause presented to the exception sequencer
   typedef enum logic [3:0] {
      EXPA_CAUSE_NONE,
      EXPA_CAUSE_SYS_RESET,
      EXPA_CAUSE_MACH_CHECK,
      EXPA_CAUSE_ALIGN,
      EXPA_CAUSE_DATA_STORAGE,
      EXPA_CAUSE_FP_UNAVAIL,
      EXPA_CAUSE_PROG_PRIV,
      EXPA_CAUSE_PROG_FP_PRECISE,
      EXPA_CAUSE_PROG_TRAP,
      EXPA_CAUSE_SYSCALL,
      EXPA_CAUSE_TRACE,
      EXPA_CAUSE_FETCH_STORAGE,
      EXPA_CAUSE_PROG_FP_IMPRECISE,
      EXPA_CAUSE_EXTERNAL,
      EXPA_CAUSE_DECREMENTER
   } expa_cause_t;

   // Instruction class of the excepting instruction
   typedef enum logic [2:0] {
      EXPA_CLS_INT_LDST,
      EXPA_CLS_FP_LDST,
      EXPA_CLS_RFI_MTSR,
      EXPA_CLS_TRAP_SC,
      EXPA_CLS_OTHER
   } expa_class_t;

   // Synchronous request from the instruction pipeline
   typedef struct packed {
      logic        valid;
      expa_class_t cls;
      logic        older_done;
      logic        align;
      logic        data_storage;
      logic        fp_unavail;
      logic        prog_priv;
      logic        prog_fp_precise;
      logic        prog_trap;
      logic        syscall;
      logic        trace;
      logic        fetch_storage;
   } expa_sync_req_t;

   // Asynchronous and imprecise sources, brought into the clock domain by two flops in the arbiter
   typedef struct packed {
      logic sys_reset;
      logic mach_check;
      logic fp_imprecise;
      logic external;
      logic decrementer;
   } expa_async_t;

   // Machine state bits that steer arbitration
   typedef struct packed {
      logic external_interrupt_enable_bit;
      logic fp_exception_mode_bit_a;
      logic fp_exception_mode_bit_b;
   } expa_msr_t;

   // Output to the sequencer
   typedef struct packed {
      logic        take;
      expa_cause_t cause;
   } expa_grant_t;

   localparam logic       EXPA_PEND_RST  = 1'b0;
   localparam logic [1:0] EXPA_SYNC_W    = 2'h2;

endpackage : expa_pkg

// ---- src/expa_arbiter.sv ----
// Exception priority arbiter: selects one exception cause per cycle
// How it works
// - System reset wins over everything and is taken immediately.
// - Machine check ranks second, beaten only by system reset.
// - Instruction exception waits for older instructions, then taken if nothing higher.
// - Integer load/store: alignment, then data storage, then trace.
// - FP load/store: FP unavailable, alignment, data storage, then trace.
// - Return/move-to-state: privileged beats precise FP enabled; trace after.
// - Trap, system call, privileged are exclusive, equal; trace below them.
// - Fetch storage fault is lowest synchronous, only when older done.
// - Imprecise FP enabled exception ranks fourth.
// - Imprecise FP mode only when the two FP mode bits differ.
// - External interrupt fifth, after dispatched instructions complete.
// - Decrementer ranks sixth, lowest of all.
// - External and decrementer taken only while enable bit set; held pending.
// - Reset and machine check accepted any time, even during a handler.
// - Machine check coinciding with reset waits; reset goes first.
// - At most one synchronous precise exception reported at a time.
// - Maskable or imprecise conditions held while instruction exceptions process.
`timescale 1ns/100ps
module expa_arbiter (
   // Clock and reset
   input  wire logic                    CLK_I,
   input  wire logic                    ARST_N_I,
   // Pipeline request
   input  wire expa_pkg::expa_sync_req_t SYNC_REQ_I,
   input  wire logic                    PIPE_DRAINED_I,
   input  wire logic                    HANDLER_DONE_I,
   // Asynchronous pins
   input  wire expa_pkg::expa_async_t   ASYNC_I,
   // Machine state
   input  wire expa_pkg::expa_msr_t     MSR_I,
   // Grant to sequencer
   output expa_pkg::expa_grant_t        GRANT_O,
   output logic                         SYNC_BUSY_O
);
   import expa_pkg::*;

   typedef struct packed {
      expa_async_t meta;
      expa_async_t sync;
      logic        ext_pend;
      logic        dec_pend;
      logic        fpi_pend;
      logic        mc_pend;
      logic        sync_busy;
      expa_grant_t grant;
   } expa_state_t;

   expa_state_t st_reg;
   expa_state_t st_next;

   ////////////////////////////////////////////////////////////////////////////
   // Ranking of the faults of one instruction
   function automatic expa_cause_t sync_pick(input expa_sync_req_t r);
      expa_cause_t c;
      c = EXPA_CAUSE_NONE;
      unique case (r.cls)
         EXPA_CLS_INT_LDST: begin
            if (r.align) c = EXPA_CAUSE_ALIGN;
            else if (r.data_storage) c = EXPA_CAUSE_DATA_STORAGE;
            else if (r.trace) c = EXPA_CAUSE_TRACE;
         end
         EXPA_CLS_FP_LDST: begin
            if (r.fp_unavail) c = EXPA_CAUSE_FP_UNAVAIL;
            else if (r.align) c = EXPA_CAUSE_ALIGN;
            else if (r.data_storage) c = EXPA_CAUSE_DATA_STORAGE;
            else if (r.trace) c = EXPA_CAUSE_TRACE;
         end
         EXPA_CLS_RFI_MTSR: begin
            if (r.prog_priv) c = EXPA_CAUSE_PROG_PRIV;
            else if (r.prog_fp_precise) c = EXPA_CAUSE_PROG_FP_PRECISE;
            else if (r.trace) c = EXPA_CAUSE_TRACE;
         end
         EXPA_CLS_TRAP_SC: begin
            // Mutually exclusive by construction; fixed order only breaks ties
            if (r.prog_trap) c = EXPA_CAUSE_PROG_TRAP;
            else if (r.syscall) c = EXPA_CAUSE_SYSCALL;
            else if (r.prog_priv) c = EXPA_CAUSE_PROG_PRIV;
            else if (r.trace) c = EXPA_CAUSE_TRACE;
         end
         EXPA_CLS_OTHER: begin
            if (r.fp_unavail) c = EXPA_CAUSE_FP_UNAVAIL;
            else if (r.prog_fp_precise) c = EXPA_CAUSE_PROG_FP_PRECISE;
            else if (r.trace) c = EXPA_CAUSE_TRACE;
         end
         default: c = EXPA_CAUSE_NONE;
      endcase
      // Fetch fault only when nothing else from this instruction
      if (c == EXPA_CAUSE_NONE && r.fetch_storage)
         c = EXPA_CAUSE_FETCH_STORAGE;
      return c;
   endfunction : sync_pick

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   expa_cause_t sync_cause;
   logic        imp_mode;
   logic        quiet;

   always_comb begin
      st_next      = st_reg;
      st_next.meta = ASYNC_I;
      st_next.sync = st_reg.meta;
      sync_cause   = (SYNC_REQ_I.valid && SYNC_REQ_I.older_done) ?
                     sync_pick(SYNC_REQ_I) : EXPA_CAUSE_NONE;
      imp_mode     = MSR_I.fp_exception_mode_bit_a
                     ^ MSR_I.fp_exception_mode_bit_b;
      quiet        = !st_reg.sync_busy && PIPE_DRAINED_I;

      // Latch pending conditions; set wins over clear
      st_next.ext_pend = st_reg.ext_pend || st_reg.sync.external;
      st_next.dec_pend = st_reg.dec_pend || st_reg.sync.decrementer;
      st_next.fpi_pend = st_reg.fpi_pend || (st_reg.sync.fp_imprecise && imp_mode);
      st_next.mc_pend  = st_reg.mc_pend  || st_reg.sync.mach_check;

      if (HANDLER_DONE_I)
         st_next.sync_busy = 1'b0;

      st_next.grant.take  = 1'b1;
      st_next.grant.cause = EXPA_CAUSE_NONE;

      if (st_reg.sync.sys_reset) begin
         st_next.grant.cause = EXPA_CAUSE_SYS_RESET;
         st_next.sync_busy   = 1'b0;
      end else if (st_reg.mc_pend) begin
         st_next.grant.cause = EXPA_CAUSE_MACH_CHECK;
         st_next.mc_pend     = st_reg.sync.mach_check;
         st_next.sync_busy   = 1'b0;
      end else if (sync_cause != EXPA_CAUSE_NONE && !st_reg.sync_busy) begin
         st_next.grant.cause = sync_cause;
         st_next.sync_busy   = 1'b1;
      end else if (st_reg.fpi_pend && quiet) begin
         st_next.grant.cause = EXPA_CAUSE_PROG_FP_IMPRECISE;
         st_next.fpi_pend    = st_reg.sync.fp_imprecise && imp_mode;
      end else if (st_reg.ext_pend && quiet
                   && MSR_I.external_interrupt_enable_bit) begin
         st_next.grant.cause = EXPA_CAUSE_EXTERNAL;
         st_next.ext_pend    = st_reg.sync.external;
      end else if (st_reg.dec_pend && quiet && sync_cause == EXPA_CAUSE_NONE
                   && MSR_I.external_interrupt_enable_bit) begin
         st_next.grant.cause = EXPA_CAUSE_DECREMENTER;
         st_next.dec_pend    = st_reg.sync.decrementer;
      end else begin
         st_next.grant.take  = 1'b0;
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign GRANT_O     = st_reg.grant;
   assign SYNC_BUSY_O = st_reg.sync_busy;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);

   AST_RESET_TOP: assert property (st_reg.sync.sys_reset |=> GRANT_O.take
      && GRANT_O.cause == EXPA_CAUSE_SYS_RESET) else $error("reset not granted");
   AST_MC_SECOND: assert property (st_reg.mc_pend && !st_reg.sync.sys_reset
      |=> GRANT_O.cause == EXPA_CAUSE_MACH_CHECK) else $error("machine check lost");
   AST_MC_DEFER: assert property (st_reg.sync.sys_reset && st_reg.mc_pend
      |=> st_reg.mc_pend) else $error("machine check dropped at reset");
   AST_EE_MASK: assert property (!MSR_I.external_interrupt_enable_bit |=>
      !(GRANT_O.cause inside {EXPA_CAUSE_EXTERNAL, EXPA_CAUSE_DECREMENTER}))
      else $error("masked interrupt taken");
   AST_EXT_HELD: assert property (st_reg.sync.external |=> st_reg.ext_pend)
      else $error("external not held");
   AST_ONE_SYNC: assert property (st_reg.sync_busy && !HANDLER_DONE_I
      && !st_reg.sync.sys_reset && !st_reg.mc_pend |=> st_reg.sync_busy)
      else $error("second precise reported");
   AST_WAIT_OLDER: assert property (SYNC_REQ_I.valid && !SYNC_REQ_I.older_done
      && !st_reg.sync.sys_reset && !st_reg.mc_pend && !st_reg.sync_busy
      && !PIPE_DRAINED_I |=> !GRANT_O.take) else $error("granted before older done");
   AST_HOLD_BUSY: assert property (st_reg.sync_busy |=>
      !(GRANT_O.cause inside {EXPA_CAUSE_EXTERNAL, EXPA_CAUSE_DECREMENTER,
      EXPA_CAUSE_PROG_FP_IMPRECISE})) else $error("maskable during handler");
   AST_IMP_MODE: assert property (st_reg.sync.fp_imprecise && !imp_mode && !st_reg.fpi_pend
      |=> !st_reg.fpi_pend) else $error("imprecise outside mode");
   AST_INT_ORDER: assert property (SYNC_REQ_I.valid && SYNC_REQ_I.older_done
      && SYNC_REQ_I.cls == EXPA_CLS_INT_LDST && SYNC_REQ_I.align && !st_reg.sync_busy
      && !st_reg.sync.sys_reset && !st_reg.mc_pend |=> GRANT_O.cause == EXPA_CAUSE_ALIGN)
      else $error("integer order wrong");


   ////////////////////////////////////////////////////////////////////////////
   // Further ordering checks
   logic arb_free;
   logic sync_ready;

   // Nothing above a precise request and no handler running
   assign arb_free   = !st_reg.sync.sys_reset && !st_reg.mc_pend && !st_reg.sync_busy;
   assign sync_ready = SYNC_REQ_I.valid && SYNC_REQ_I.older_done;

   AST_INT_DSI: assert property (sync_ready && arb_free
      && SYNC_REQ_I.cls == EXPA_CLS_INT_LDST && !SYNC_REQ_I.align
      && SYNC_REQ_I.data_storage |=> GRANT_O.cause == EXPA_CAUSE_DATA_STORAGE)
      else $error("integer storage fault order wrong");

   AST_FP_FIRST: assert property (sync_ready && arb_free
      && SYNC_REQ_I.cls == EXPA_CLS_FP_LDST && SYNC_REQ_I.fp_unavail
      |=> GRANT_O.cause == EXPA_CAUSE_FP_UNAVAIL)
      else $error("fp unavailable not first");

   AST_FP_ALIGN: assert property (sync_ready && arb_free
      && SYNC_REQ_I.cls == EXPA_CLS_FP_LDST && !SYNC_REQ_I.fp_unavail
      && SYNC_REQ_I.align |=> GRANT_O.cause == EXPA_CAUSE_ALIGN)
      else $error("fp alignment order wrong");

   AST_RFI_PRIV: assert property (sync_ready && arb_free
      && SYNC_REQ_I.cls == EXPA_CLS_RFI_MTSR && SYNC_REQ_I.prog_priv
      |=> GRANT_O.cause == EXPA_CAUSE_PROG_PRIV)
      else $error("privileged not first on return");

   AST_RFI_FPP: assert property (sync_ready && arb_free
      && SYNC_REQ_I.cls == EXPA_CLS_RFI_MTSR && !SYNC_REQ_I.prog_priv
      && SYNC_REQ_I.prog_fp_precise |=> GRANT_O.cause == EXPA_CAUSE_PROG_FP_PRECISE)
      else $error("precise fp order wrong");

   AST_TRAP_EXCL: assert property (sync_ready && arb_free
      && SYNC_REQ_I.cls == EXPA_CLS_TRAP_SC
      && (SYNC_REQ_I.prog_trap || SYNC_REQ_I.syscall || SYNC_REQ_I.prog_priv)
      |=> GRANT_O.cause inside {EXPA_CAUSE_PROG_TRAP, EXPA_CAUSE_SYSCALL,
      EXPA_CAUSE_PROG_PRIV}) else $error("trap group lost to trace");

   AST_FETCH_LAST: assert property (sync_ready && arb_free
      && SYNC_REQ_I.cls == EXPA_CLS_INT_LDST && SYNC_REQ_I.data_storage
      |=> GRANT_O.cause != EXPA_CAUSE_FETCH_STORAGE)
      else $error("fetch fault favoured");

   AST_FETCH_WAIT: assert property (SYNC_REQ_I.valid && !SYNC_REQ_I.older_done
      && SYNC_REQ_I.fetch_storage
      |=> GRANT_O.cause != EXPA_CAUSE_FETCH_STORAGE)
      else $error("fetch fault before older done");

   AST_FPI_FOURTH: assert property (st_reg.fpi_pend && arb_free && PIPE_DRAINED_I
      && !sync_ready |=> GRANT_O.cause == EXPA_CAUSE_PROG_FP_IMPRECISE)
      else $error("imprecise fp not taken");

   AST_EXT_DRAIN: assert property (!PIPE_DRAINED_I
      |=> !(GRANT_O.cause inside {EXPA_CAUSE_EXTERNAL, EXPA_CAUSE_DECREMENTER,
      EXPA_CAUSE_PROG_FP_IMPRECISE})) else $error("taken before drain");

   AST_DEC_LAST: assert property (st_reg.ext_pend
      |=> GRANT_O.cause != EXPA_CAUSE_DECREMENTER)
      else $error("decrementer beat external");

   AST_MC_ANYTIME: assert property (st_reg.mc_pend && st_reg.sync_busy
      && !st_reg.sync.sys_reset
      |=> GRANT_O.cause == EXPA_CAUSE_MACH_CHECK && !SYNC_BUSY_O)
      else $error("machine check deferred by handler");

   AST_RESET_CLR: assert property (st_reg.sync.sys_reset |=> !SYNC_BUSY_O)
      else $error("handler survives reset");

   AST_SYNC_BUSY: assert property (GRANT_O.cause inside
      {[EXPA_CAUSE_ALIGN:EXPA_CAUSE_FETCH_STORAGE]} |-> SYNC_BUSY_O)
      else $error("precise grant without busy");

   AST_ONE_CAUSE: assert property (GRANT_O.take == (GRANT_O.cause != EXPA_CAUSE_NONE))
      else $error("take and cause disagree");

   ////////////////////////////////////////////////////////////////////////////
   // Main scenarios
   COV_RESET: cover property (GRANT_O.cause == EXPA_CAUSE_SYS_RESET);
   COV_MC:    cover property (GRANT_O.cause == EXPA_CAUSE_MACH_CHECK);
   COV_SYNC:  cover property (GRANT_O.cause == EXPA_CAUSE_DATA_STORAGE);
   COV_EXT:   cover property (GRANT_O.cause == EXPA_CAUSE_EXTERNAL);
   COV_DEC:   cover property (GRANT_O.cause == EXPA_CAUSE_DECREMENTER);

endmodule : expa_arbiter

// ---- verif/expa_pipe_model.sv ----
// Pipeline model: holds one request until granted, then ends the handler
`timescale 1ns/100ps
module expa_pipe_model
   import expa_pkg::*;
(
   // Clock and reset
   input  wire logic           clk_i,
   input  wire logic           arst_n_i,
   // Bench command
   input  wire logic           load_i,
   input  wire expa_sync_req_t req_i,
   input  wire logic [3:0]     dly_i,
   // Arbiter side
   input  wire expa_grant_t    grant_i,
   output expa_sync_req_t      req_o,
   output logic                done_o
);
   logic [3:0] cnt_reg;
   logic       busy_reg;
   logic       sync_win;

   assign sync_win = grant_i.take && grant_i.cause >= EXPA_CAUSE_ALIGN
                     && grant_i.cause <= EXPA_CAUSE_FETCH_STORAGE;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         req_o    <= '0;
         done_o   <= 1'b0;
         cnt_reg  <= 4'h0;
         busy_reg <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (load_i) begin
            req_o <= req_i;
         end else if (sync_win) begin
            // Retired request leaves junk behind, not the old flags
            req_o    <= {1'b0, ~req_o[$bits(req_o)-2:0]};
            busy_reg <= 1'b1;
            cnt_reg  <= dly_i;
         end else if (busy_reg) begin
            if (cnt_reg == 4'h0) begin
               done_o   <= 1'b1;
               busy_reg <= 1'b0;
            end else begin
               cnt_reg <= cnt_reg - 4'h1;
            end
         end
      end
   end
endmodule : expa_pipe_model

// ---- verif/tb_exception_priority_arbiter.sv ----
// Self-checking bench for the exception priority arbiter
`timescale 1ns/100ps
module tb_exception_priority_arbiter;
   import expa_pkg::*;
   logic clk, rst_n, drained, load, busy, done;
   logic [3:0] dly;
   expa_sync_req_t req_in, sync_req;
   expa_async_t async_in;
   expa_msr_t machine_state_register;
   expa_grant_t grant;
   int err_count = 0;
   int total_checks = 0;

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   expa_arbiter DUT (.CLK_I(clk), .ARST_N_I(rst_n), .SYNC_REQ_I(sync_req),
      .PIPE_DRAINED_I(drained), .HANDLER_DONE_I(done), .ASYNC_I(async_in),
      .MSR_I(machine_state_register), .GRANT_O(grant), .SYNC_BUSY_O(busy));
   expa_pipe_model PIPE (.clk_i(clk), .arst_n_i(rst_n), .load_i(load), .req_i(req_in),
      .dly_i(dly), .grant_i(grant), .req_o(sync_req), .done_o(done));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask : check

   task automatic expect_take(input expa_cause_t c, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (grant.take !== 1'b1 && n < lim);
      check(grant.take === 1'b1 && grant.cause === c, "grant missing or wrong cause");
   endtask : expect_take

   task automatic expect_quiet(input int n);
      repeat (n) begin
         @(negedge clk);
         check(grant.take === 1'b0, "grant while it should be held");
      end
   endtask : expect_quiet

   task automatic send(input expa_class_t cls, input logic [8:0] f, input logic od);
      @(posedge clk);
      load   <= 1'b1;
      req_in <= {1'b1, cls, od, f};
      @(posedge clk);
      load <= 1'b0;
   endtask : send

   task automatic pulse(input expa_async_t a);
      @(posedge clk);
      async_in <= a;
      @(posedge clk);
      async_in <= '0;
   endtask : pulse

   task automatic one_sync(input expa_class_t cls, input logic [8:0] f, input expa_cause_t c);
      send(cls, f, 1'b1);
      expect_take(c, 8);
      repeat (20) if (busy === 1'b1) @(negedge clk);
      check(busy === 1'b0, "busy not released by handler end");
   endtask : one_sync

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_sync;
      one_sync(EXPA_CLS_INT_LDST, 9'h182, EXPA_CAUSE_ALIGN);
      one_sync(EXPA_CLS_INT_LDST, 9'h082, EXPA_CAUSE_DATA_STORAGE);
      one_sync(EXPA_CLS_INT_LDST, 9'h002, EXPA_CAUSE_TRACE);
      one_sync(EXPA_CLS_FP_LDST, 9'h1c2, EXPA_CAUSE_FP_UNAVAIL);
      one_sync(EXPA_CLS_FP_LDST, 9'h182, EXPA_CAUSE_ALIGN);
      one_sync(EXPA_CLS_FP_LDST, 9'h082, EXPA_CAUSE_DATA_STORAGE);
      one_sync(EXPA_CLS_RFI_MTSR, 9'h032, EXPA_CAUSE_PROG_PRIV);
      one_sync(EXPA_CLS_RFI_MTSR, 9'h012, EXPA_CAUSE_PROG_FP_PRECISE);
      one_sync(EXPA_CLS_TRAP_SC, 9'h00a, EXPA_CAUSE_PROG_TRAP);
      one_sync(EXPA_CLS_TRAP_SC, 9'h006, EXPA_CAUSE_SYSCALL);
      one_sync(EXPA_CLS_TRAP_SC, 9'h022, EXPA_CAUSE_PROG_PRIV);
      one_sync(EXPA_CLS_INT_LDST, 9'h081, EXPA_CAUSE_DATA_STORAGE);
      one_sync(EXPA_CLS_OTHER, 9'h001, EXPA_CAUSE_FETCH_STORAGE);
   endtask : t_sync

   task automatic t_busy;
      send(EXPA_CLS_OTHER, 9'h001, 1'b0);
      expect_quiet(5);
      dly <= 4'h8;
      send(EXPA_CLS_INT_LDST, 9'h100, 1'b1);
      expect_take(EXPA_CAUSE_ALIGN, 8);
      send(EXPA_CLS_OTHER, 9'h001, 1'b1);
      expect_quiet(5);
      expect_take(EXPA_CAUSE_FETCH_STORAGE, 20);
      dly <= 4'h0;
   endtask : t_busy

   task automatic t_mask;
      @(posedge clk);
      machine_state_register.external_interrupt_enable_bit <= 1'b0;
      pulse('{default: 1'b0, external: 1'b1});
      expect_quiet(8);
      @(posedge clk);
      machine_state_register.external_interrupt_enable_bit <= 1'b1;
      expect_take(EXPA_CAUSE_EXTERNAL, 6);
      @(posedge clk);
      drained <= 1'b0;
      pulse('{default: 1'b0, external: 1'b1});
      expect_quiet(6);
      @(posedge clk);
      drained <= 1'b1;
      expect_take(EXPA_CAUSE_EXTERNAL, 6);
      pulse('{default: 1'b0, external: 1'b1});
      send(EXPA_CLS_INT_LDST, 9'h100, 1'b1);
      expect_take(EXPA_CAUSE_ALIGN, 8);
      expect_take(EXPA_CAUSE_EXTERNAL, 12);
   endtask : t_mask

   task automatic t_low;
      @(posedge clk);
      machine_state_register.fp_exception_mode_bit_a <= 1'b1;
      pulse('{default: 1'b0, fp_imprecise: 1'b1, external: 1'b1, decrementer: 1'b1});
      expect_take(EXPA_CAUSE_PROG_FP_IMPRECISE, 8);
      expect_take(EXPA_CAUSE_EXTERNAL, 6);
      expect_take(EXPA_CAUSE_DECREMENTER, 6);
      @(posedge clk);
      machine_state_register.fp_exception_mode_bit_a <= 1'b0;
      pulse('{default: 1'b0, fp_imprecise: 1'b1});
      expect_quiet(8);
   endtask : t_low

   task automatic t_nonmask;
      dly <= 4'hf;
      send(EXPA_CLS_INT_LDST, 9'h100, 1'b1);
      expect_take(EXPA_CAUSE_ALIGN, 8);
      pulse('{default: 1'b0, mach_check: 1'b1});
      expect_take(EXPA_CAUSE_MACH_CHECK, 6);
      pulse('{default: 1'b0, sys_reset: 1'b1, mach_check: 1'b1, external: 1'b1});
      expect_take(EXPA_CAUSE_SYS_RESET, 6);
      expect_take(EXPA_CAUSE_MACH_CHECK, 6);
      dly <= 4'h0;
   endtask : t_nonmask

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   initial begin
      #(40 * 3000);
      err_count++;
      conclude();
   end

   initial begin
      rst_n = 1'b0;
      drained = 1'b1;
      load = 1'b0;
      dly = 4'h0;
      req_in = '0;
      async_in = '0;
      machine_state_register = '{external_interrupt_enable_bit: 1'b1, default: 1'b0};
      repeat (8) @(posedge clk);
      check(grant.take === 1'b0, "grant during reset");
      rst_n <= 1'b1;
      t_sync();
      t_busy();
      t_mask();
      t_low();
      t_nonmask();
      conclude();
   end
endmodule : tb_exception_priority_arbiter
